// [dv/scsi_irq_status_dma_control_bench.sv]
module scsi_irq_status_dma_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } sidc_row_type;
    logic                        clk_i;
    logic                        rst_n_i = 1'b0;
    logic [7:0]                  addr_i = 8'h00;
    logic [31:0]                 wdata_i = 32'h0;
    logic                        wr_i = 1'b0;
    logic                        rd_i = 1'b0;
    logic                        dma_pending_flag_i = 1'b0;
    sidc_pkg::sidc_engine_type   engine_i = '{1'b0, 1'b0, 32'h1357_9BDF};
    sidc_pkg::sidc_scsi_evt_type scsi_evt_i;
    logic [31:0]                 rdata_o;
    logic                        fetch_req_o;
    logic                        engine_running_o;
    logic                        step_irq_o;
    logic                        scsi_pending_flag_o;
    logic                        irq_n_o;
    logic                        irq_n_oe_o;
    logic                        irq_pullup_o;
    wire                         irq_pin = irq_n_oe_o ? irq_n_o : 1'b1;
    int                          error_cnt = 0;
    int                          tests_run = 0;
    sidc_row_type                rows [8] = '{
        '{8'h40, 32'hFF, 32'hFF}, '{8'h41, 32'hFF, 32'h07}, '{8'h38, 32'h01, 32'h01},
        '{8'h3B, 32'h08, 32'h08}, '{8'h52, 32'hA5, 32'hA5}, '{8'h42, 32'hFF, 32'h00},
        '{8'h3C, 32'hFF, 32'h1357_9BDF}, '{8'h7F, 32'hFF, 32'h00}};
    sidc_core sidc_core_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .scsi_evt_i(scsi_evt_i), .engine_i(engine_i),
        .dma_pending_flag_i(dma_pending_flag_i), .fetch_req_o(fetch_req_o),
        .engine_running_o(engine_running_o), .step_irq_o(step_irq_o),
        .scsi_pending_flag_o(scsi_pending_flag_o), .irq_n_o(irq_n_o),
        .irq_n_oe_o(irq_n_oe_o), .irq_pullup_o(irq_pullup_o));
    sidc_peer sidc_peer_inst (.clk_i(clk_i), .scsi_evt_o(scsi_evt_i));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 check(rdata_o, e);
        @(posedge clk_i);
        if (a == 8'h42 || a == 8'h43) repeat (12) @(posedge clk_i);
    endtask
    task automatic epulse(input logic done, input logic dirq);
        engine_i.instr_done <= done;
        engine_i.dma_irq <= dirq;
        @(posedge clk_i);
        engine_i.instr_done <= 1'b0;
        engine_i.dma_irq <= 1'b0;
    endtask
    task automatic fin(input string s);
        $display("test %s done, mismatches %0d", s, error_cnt);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rdc(8'h40, 32'h0);
        rdc(8'h3B, 32'h0);
        check({31'h0, irq_pullup_o}, 32'h1);
        fin("reset");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        check({31'h0, irq_pullup_o}, 32'h0);
        fin("registers");
        wr(8'h40, 32'h0);
        wr(8'h41, 32'h0);
        wr(8'h3B, 32'h0);
        sidc_peer_inst.pulse('{fifo_overflow: 1'b1, residual_fifo: 1'b1, default: '0});
        rdc(8'h42, 32'h08);
        check({31'h0, irq_n_oe_o}, 32'h0);
        rdc(8'h42, 32'h0);
        sidc_peer_inst.pulse('{arb_done: 1'b1, atn_asserted: 1'b1, default: '0});
        rdc(8'h42, 32'hC0);
        sidc_peer_inst.pulse('{initiator_mode: 1'b1, req_edge: 1'b1, target_phase: 3'd5,
                               disconnect_evt: 1'b1, default: '0});
        rdc(8'h42, 32'h84);
        sidc_peer_inst.pulse('{selected_evt: 1'b1, peer_id: 3'd5, default: '0});
        rdc(8'h42, 32'h0);
        wr(8'h51, 32'h45);
        sidc_peer_inst.pulse('{selected_evt: 1'b1, peer_id: 3'd5, default: '0});
        rdc(8'h42, 32'h20);
        rdc(8'h55, 32'h05);
        wr(8'h3B, 32'h01);
        wr(8'h51, 32'h25);
        sidc_peer_inst.pulse('{reselected_evt: 1'b1, peer_id: 3'd7, default: '0});
        rdc(8'h42, 32'h10);
        rdc(8'h54, 32'h07);
        rdc(8'h55, 32'h05);
        wr(8'h3B, 32'h0);
        sidc_peer_inst.set_level('{bus_reset_line: 1'b1, default: '0});
        rdc(8'h42, 32'h02);
        rdc(8'h42, 32'h0);
        sidc_peer_inst.set_level('0);
        sidc_peer_inst.pulse('{scsi_parity_err: 1'b1, default: '0});
        rdc(8'h42, 32'h0);
        wr(8'h50, 32'h08);
        sidc_peer_inst.pulse('{scsi_parity_err: 1'b1, default: '0});
        rdc(8'h42, 32'h01);
        sidc_peer_inst.pulse('{host_parity_err: 1'b1, default: '0});
        rdc(8'h42, 32'h01);
        wr(8'h50, 32'h0C);
        sidc_peer_inst.pulse('{host_parity_err: 1'b1, default: '0});
        rdc(8'h42, 32'h0);
        fin("status zero");
        wr(8'h41, 32'h07);
        sidc_peer_inst.pulse('{sel_timeout: 1'b1, default: '0});
        @(posedge clk_i);
        #1 check({31'h0, irq_pin}, 32'h0);
        @(posedge clk_i);
        wr(8'h41, 32'h0);
        check({31'h0, irq_n_oe_o}, 32'h1);
        rdc(8'h43, 32'h04);
        check({31'h0, irq_n_oe_o}, 32'h1);
        rdc(8'h42, 32'h04);
        check({31'h0, irq_n_oe_o}, 32'h0);
        sidc_peer_inst.pulse('{aux_timer_expired: 1'b1, handshake_gap_timeout: 1'b1,
                               default: '0});
        rdc(8'h43, 32'h03);
        check({31'h0, irq_n_oe_o}, 32'h0);
        fin("status one");
        wr(8'h3B, 32'h14);
        #1 check({31'h0, fetch_req_o}, 32'h1);
        @(posedge clk_i);
        epulse(1'b1, 1'b0);
        #1 check({31'h0, step_irq_o, engine_running_o}, 32'h2);
        repeat (3) @(posedge clk_i);
        #1 check({31'h0, engine_running_o}, 32'h0);
        @(posedge clk_i);
        wr(8'h3B, 32'h14);
        #1 check({31'h0, engine_running_o}, 32'h1);
        @(posedge clk_i);
        epulse(1'b0, 1'b1);
        wr(8'h3B, 32'h04);
        repeat (3) begin
            epulse(1'b1, 1'b0);
            @(posedge clk_i);
        end
        #1 check({31'h0, engine_running_o}, 32'h1);
        @(posedge clk_i);
        epulse(1'b0, 1'b1);
        #1 check({31'h0, engine_running_o}, 32'h0);
        fin("engine");
        test_done();
    end
endmodule

// [dv/sidc_core_checker.sv]
module sidc_core_checker (
    input wire logic                        clk_i,
    input wire logic                        rst_n_i,
    input wire logic [7:0]                  addr_i,
    input wire logic [31:0]                 wdata_i,
    input wire logic                        wr_i,
    input wire logic                        rd_i,
    input wire logic [31:0]                 rdata_o,
    input wire sidc_pkg::sidc_scsi_evt_type scsi_evt_i,
    input wire sidc_pkg::sidc_engine_type   engine_i,
    input wire logic                        dma_pending_flag_i,
    input wire logic                        fetch_req_o,
    input wire logic                        engine_running_o,
    input wire logic                        step_irq_o,
    input wire logic                        scsi_pending_flag_o,
    input wire logic                        irq_n_o,
    input wire logic                        irq_n_oe_o,
    input wire logic                        irq_pullup_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data outside read slot");
    a_drive_low: assert property (irq_n_oe_o |-> !irq_n_o)
        else $error("interrupt pin driven high");
    a_pullup_mode: assert property (
        wr_i && addr_i == 8'h3B |=> irq_pullup_o == !$past(wdata_i[3]))
        else $error("pull-up does not follow driver select");
    a_trigger_fetch: assert property (
        wr_i && addr_i == 8'h3B && wdata_i[2] && !engine_running_o |=> fetch_req_o)
        else $error("no fetch after start trigger");
    a_step_halt: assert property (
        step_irq_o |-> !engine_running_o && $past(engine_i.instr_done))
        else $error("step pulse without halt after instruction");
    a_run_continue: assert property (
        engine_running_o && !engine_i.instr_done && !engine_i.dma_irq && scsi_evt_i == '0
        |=> engine_running_o)
        else $error("engine stopped without cause");
    a_irq_latched: assert property (
        irq_n_oe_o && !rd_i && scsi_pending_flag_o |=> irq_n_oe_o)
        else $error("interrupt dropped without status read");
    a_timeout_flag: assert property (scsi_evt_i.sel_timeout |=> scsi_pending_flag_o)
        else $error("timeout not recorded");
    a_reset_edge: assert property (
        $rose(scsi_evt_i.bus_reset_line) |=> scsi_pending_flag_o)
        else $error("bus reset edge not recorded");
endmodule

bind sidc_core sidc_core_checker sidc_core_checker_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .scsi_evt_i(scsi_evt_i), .engine_i(engine_i),
    .dma_pending_flag_i(dma_pending_flag_i), .fetch_req_o(fetch_req_o),
    .engine_running_o(engine_running_o), .step_irq_o(step_irq_o),
    .scsi_pending_flag_o(scsi_pending_flag_o), .irq_n_o(irq_n_o),
    .irq_n_oe_o(irq_n_oe_o), .irq_pullup_o(irq_pullup_o));

// [dv/sidc_peer.sv]
module sidc_peer (
    input  wire logic                   clk_i,
    output sidc_pkg::sidc_scsi_evt_type scsi_evt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    sidc_pkg::sidc_scsi_evt_type lvl_reg = '0;
    sidc_pkg::sidc_scsi_evt_type pls_reg = '0;
    // held bus levels with one-clock events on top
    assign scsi_evt_o = lvl_reg | pls_reg;
    task automatic set_level(input sidc_pkg::sidc_scsi_evt_type v);
        lvl_reg <= v;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic pulse(input sidc_pkg::sidc_scsi_evt_type v);
        pls_reg <= v;
        @(posedge clk_i);
        pls_reg <= '0;
        @(posedge clk_i);
    endtask
endmodule

// [rtl/sidc_core.sv]
// Implementation choice: the strobed register port.
`include "sidc_params.svh"

module sidc_core (
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic [7:0]                  addr_i,
    input  wire logic [31:0]                 wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [31:0]                 rdata_o,
    input  wire sidc_pkg::sidc_scsi_evt_type scsi_evt_i,
    input  wire sidc_pkg::sidc_engine_type   engine_i,
    input  wire logic                        dma_pending_flag_i,
    output logic                             fetch_req_o,
    output logic                             engine_running_o,
    output logic                             step_irq_o,
    output logic                             scsi_pending_flag_o,
    output logic                             irq_n_o,
    output logic                             irq_n_oe_o,
    output logic                             irq_pullup_o
);

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    logic [7:0] dma_mode_reg;
    logic [7:0] dma_engine_control_reg;
    logic [7:0] scsi_ctrl_zero_reg;
    logic [7:0] own_id_control_reg;
    logic [7:0] answer_id_mask_reg;
    logic [7:0] scsi_irq_enable_zero_reg;
    logic [7:0] scsi_irq_enable_one_reg;
    logic [7:0] scsi_irq_status_zero_reg;
    logic [7:0] scsi_irq_status_one_reg;
    logic [7:0] captured_peer_id_reg;
    logic [7:0] first_byte_reg_reg;
    logic [31:0] adder_reg;
    logic        irq_latch_reg;
    logic        bus_reset_seen_reg;
    logic        step_irq_reg;
    sidc_pkg::sidc_eng_state_type eng_state_reg;

    logic rd_s0;
    logic rd_s1;
    logic wr_trig;
    logic [7:0] set0;
    logic [7:0] set1;
    logic [7:0] clr0;
    logic [7:0] clr1;
    logic       id_match;
    logic       gross_err;

    assign rd_s0   = rd_i && (addr_i == `SIDC_OFS_ST0);
    assign rd_s1   = rd_i && (addr_i == `SIDC_OFS_ST1);
    assign wr_trig = wr_i && (addr_i == `SIDC_OFS_DCTRL) && wdata_i[`SIDC_DC_TRIG];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dma_mode_reg             <= `SIDC_RST_BYTE;
            dma_engine_control_reg   <= `SIDC_RST_BYTE;
            scsi_ctrl_zero_reg       <= `SIDC_RST_BYTE;
            own_id_control_reg       <= `SIDC_RST_BYTE;
            answer_id_mask_reg       <= `SIDC_RST_BYTE;
            scsi_irq_enable_zero_reg <= `SIDC_RST_BYTE;
            scsi_irq_enable_one_reg  <= `SIDC_RST_BYTE;
        end else if (wr_i) begin
            case (addr_i)
                `SIDC_OFS_MODE: dma_mode_reg <= wdata_i[7:0];
                `SIDC_OFS_DCTRL: dma_engine_control_reg <= wdata_i[7:0] & `SIDC_DC_MASK;
                `SIDC_OFS_SCTL0: scsi_ctrl_zero_reg <= wdata_i[7:0];
                `SIDC_OFS_OWNID: own_id_control_reg <= wdata_i[7:0];
                `SIDC_OFS_ANSID: answer_id_mask_reg <= wdata_i[7:0];
                `SIDC_OFS_EN0: scsi_irq_enable_zero_reg <= wdata_i[7:0];
                `SIDC_OFS_EN1: scsi_irq_enable_one_reg <= wdata_i[7:0] & `SIDC_S1_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= `SIDC_RST_WORD;
        end else if (rd_i) begin
            case (addr_i)
                `SIDC_OFS_MODE:   rdata_o <= {24'h000000, dma_mode_reg};
                `SIDC_OFS_DCTRL:  rdata_o <= {24'h000000, dma_engine_control_reg};
                `SIDC_OFS_ADDER:  rdata_o <= adder_reg;
                `SIDC_OFS_EN0:    rdata_o <= {24'h000000, scsi_irq_enable_zero_reg};
                `SIDC_OFS_EN1:    rdata_o <= {24'h000000, scsi_irq_enable_one_reg};
                `SIDC_OFS_ST0:    rdata_o <= {24'h000000, scsi_irq_status_zero_reg};
                `SIDC_OFS_ST1:    rdata_o <= {24'h000000, scsi_irq_status_one_reg};
                `SIDC_OFS_SCTL0:  rdata_o <= {24'h000000, scsi_ctrl_zero_reg};
                `SIDC_OFS_OWNID:  rdata_o <= {24'h000000, own_id_control_reg};
                `SIDC_OFS_ANSID:  rdata_o <= {24'h000000, answer_id_mask_reg};
                `SIDC_OFS_ENGST:  rdata_o <= {29'h00000000, eng_state_reg};
                `SIDC_OFS_PEERID: rdata_o <= {24'h000000, captured_peer_id_reg};
                `SIDC_OFS_FBYTE:  rdata_o <= {24'h000000, first_byte_reg_reg};
                default:          rdata_o <= `SIDC_RST_WORD;
            endcase
        end else begin
            rdata_o <= `SIDC_RST_WORD;
        end
    end

    // ----------------------------------------
    // adder capture
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            adder_reg <= `SIDC_RST_WORD;
        end else begin
            adder_reg <= engine_i.adder_sum;
        end
    end

    // ----------------------------------------
    // status event decode
    // ----------------------------------------
    assign id_match = answer_id_mask_reg[scsi_evt_i.peer_id];
    assign gross_err = scsi_evt_i.fifo_underflow | scsi_evt_i.fifo_overflow
                     | (!scsi_evt_i.initiator_mode & scsi_evt_i.offset_underflow)
                     | (scsi_evt_i.initiator_mode & scsi_evt_i.offset_overflow)
                     | (scsi_evt_i.initiator_mode & scsi_evt_i.phase_chg_offset)
                     | scsi_evt_i.residual_fifo;

    always_comb begin
        set0 = `SIDC_RST_BYTE;
        set0[`SIDC_S0_MA] = scsi_evt_i.initiator_mode
            ? (scsi_evt_i.req_edge && scsi_evt_i.target_phase != scsi_evt_i.expected_phase)
            : scsi_evt_i.atn_asserted;
        set0[`SIDC_S0_DONE] = scsi_evt_i.arb_done | scsi_evt_i.arb_sel_done;
        set0[`SIDC_S0_SEL] = scsi_evt_i.selected_evt & id_match
                           & own_id_control_reg[`SIDC_OID_SELEN];
        set0[`SIDC_S0_RESEL] = scsi_evt_i.reselected_evt & id_match
                             & own_id_control_reg[`SIDC_OID_RSLEN];
        set0[`SIDC_S0_GROSS] = gross_err;
        set0[`SIDC_S0_DROP] = (scsi_evt_i.disconnect_evt
                              & ((scsi_evt_i.initiator_mode & !scsi_evt_i.disconnect_expected)
                                 | scsi_evt_i.low_level_mode))
                           | scsi_evt_i.sel_timeout;
        set0[`SIDC_S0_RST] = scsi_evt_i.bus_reset_line & !bus_reset_seen_reg;
        set0[`SIDC_S0_PERR] = scsi_ctrl_zero_reg[`SIDC_SC0_PARCHK]
            & (scsi_evt_i.scsi_parity_err
               | (scsi_evt_i.host_parity_err
                  & !scsi_ctrl_zero_reg[`SIDC_SC0_PASSPAR]));
        set1 = `SIDC_RST_BYTE;
        set1[`SIDC_S1_SELTO] = scsi_evt_i.sel_timeout;
        set1[`SIDC_S1_AUX] = scsi_evt_i.aux_timer_expired;
        set1[`SIDC_S1_HSHK] = scsi_evt_i.handshake_gap_timeout;
    end

    assign clr0 = rd_s0 ? scsi_irq_status_zero_reg : `SIDC_RST_BYTE;
    assign clr1 = rd_s1 ? scsi_irq_status_one_reg : `SIDC_RST_BYTE;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_reset_seen_reg <= 1'b0;
        end else begin
            bus_reset_seen_reg <= scsi_evt_i.bus_reset_line;
        end
    end

    // ----------------------------------------
    // sticky status, set wins over clear
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scsi_irq_status_zero_reg <= `SIDC_RST_BYTE;
            scsi_irq_status_one_reg  <= `SIDC_RST_BYTE;
        end else begin
            scsi_irq_status_zero_reg <= (scsi_irq_status_zero_reg & ~clr0) | set0;
            scsi_irq_status_one_reg  <= (scsi_irq_status_one_reg & ~clr1) | set1;
        end
    end

    // ----------------------------------------
    // captured ID storage
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            captured_peer_id_reg <= `SIDC_RST_BYTE;
            first_byte_reg_reg   <= `SIDC_RST_BYTE;
        end else if (set0[`SIDC_S0_SEL] | set0[`SIDC_S0_RESEL]) begin
            captured_peer_id_reg <= {5'h00, scsi_evt_i.peer_id};
            if (!dma_engine_control_reg[`SIDC_DC_LEGACY]) begin
                first_byte_reg_reg <= {5'h00, scsi_evt_i.peer_id};
            end
        end
    end

    // ----------------------------------------
    // host interrupt, latched
    // ----------------------------------------
    logic irq_cause;
    assign irq_cause = |(set0 & scsi_irq_enable_zero_reg)
                     | |(set1 & scsi_irq_enable_one_reg)
                     | |(scsi_irq_status_zero_reg & ~clr0 & scsi_irq_enable_zero_reg)
                     | |(scsi_irq_status_one_reg & ~clr1 & scsi_irq_enable_one_reg);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_latch_reg <= 1'b0;
        end else if (irq_cause | engine_i.dma_irq | step_irq_reg) begin
            irq_latch_reg <= 1'b1;
        end else if (rd_s0 | rd_s1 | !dma_pending_flag_i) begin
            irq_latch_reg <= (|scsi_irq_status_zero_reg & ~rd_s0 & 1'b0)
                           | (dma_pending_flag_i & 1'b0)
                           | ((|(scsi_irq_status_zero_reg & ~clr0))
                              | (|(scsi_irq_status_one_reg & ~clr1)))
                             & irq_latch_reg;
        end
    end

    assign scsi_pending_flag_o = |scsi_irq_status_zero_reg | |scsi_irq_status_one_reg;
    assign irq_n_o      = 1'b0;
    assign irq_n_oe_o   = irq_latch_reg;
    assign irq_pullup_o = !dma_engine_control_reg[`SIDC_DC_IRQDRV];

    // ----------------------------------------
    // script engine sequencing
    // ----------------------------------------
    logic any_irq;
    assign any_irq = irq_cause | engine_i.dma_irq;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            eng_state_reg <= sidc_pkg::SIDC_IDLE;
            step_irq_reg  <= 1'b0;
        end else begin
            step_irq_reg <= 1'b0;
            case (eng_state_reg)
                sidc_pkg::SIDC_IDLE: begin
                    if (wr_trig) begin
                        eng_state_reg <= sidc_pkg::SIDC_RUN;
                    end
                end
                sidc_pkg::SIDC_RUN: begin
                    if (any_irq) begin
                        eng_state_reg <= sidc_pkg::SIDC_IDLE;
                    end else if (engine_i.instr_done
                                 && dma_engine_control_reg[`SIDC_DC_STEP]) begin
                        eng_state_reg <= sidc_pkg::SIDC_HALT;
                        step_irq_reg  <= 1'b1;
                    end
                end
                sidc_pkg::SIDC_HALT: begin
                    if (wr_trig) begin
                        eng_state_reg <= sidc_pkg::SIDC_RUN;
                    end
                end
                default: eng_state_reg <= sidc_pkg::SIDC_IDLE;
            endcase
        end
    end

    assign fetch_req_o      = eng_state_reg == sidc_pkg::SIDC_RUN;
    assign engine_running_o = eng_state_reg == sidc_pkg::SIDC_RUN;
    assign step_irq_o       = step_irq_reg;

endmodule

// [rtl/sidc_params.svh]
`ifndef SIDC_PARAMS_SVH
`define SIDC_PARAMS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SIDC_OFS_MODE     8'h38
`define SIDC_OFS_DCTRL    8'h3B
`define SIDC_OFS_ADDER    8'h3C
`define SIDC_OFS_EN0      8'h40
`define SIDC_OFS_EN1      8'h41
`define SIDC_OFS_ST0      8'h42
`define SIDC_OFS_ST1      8'h43
`define SIDC_OFS_SCTL0    8'h50
`define SIDC_OFS_OWNID    8'h51
`define SIDC_OFS_ANSID    8'h52
`define SIDC_OFS_ENGST    8'h53
`define SIDC_OFS_PEERID   8'h54
`define SIDC_OFS_FBYTE    8'h55
// ----------------------------------------
// field positions
// ----------------------------------------
`define SIDC_DC_STEP      4
`define SIDC_DC_IRQDRV    3
`define SIDC_DC_TRIG      2
`define SIDC_DC_LEGACY    0
`define SIDC_DM_DEFER     0
`define SIDC_SC0_PARCHK   3
`define SIDC_SC0_PASSPAR  2
`define SIDC_OID_SELEN    6
`define SIDC_OID_RSLEN    5
`define SIDC_OID_ID_LSB   0
`define SIDC_S0_MA        7
`define SIDC_S0_DONE      6
`define SIDC_S0_SEL       5
`define SIDC_S0_RESEL     4
`define SIDC_S0_GROSS     3
`define SIDC_S0_DROP      2
`define SIDC_S0_RST       1
`define SIDC_S0_PERR      0
`define SIDC_S1_SELTO     2
`define SIDC_S1_AUX       1
`define SIDC_S1_HSHK      0
// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define SIDC_RST_BYTE     8'h00
`define SIDC_S1_MASK      8'h07
`define SIDC_DC_MASK      8'h19
`define SIDC_RST_WORD     32'h0000_0000
`endif

// [rtl/sidc_pkg.sv]
package sidc_pkg;
    typedef enum logic [2:0] {
        SIDC_IDLE  = 3'b001,
        SIDC_RUN   = 3'b010,
        SIDC_HALT  = 3'b100
    } sidc_eng_state_type;

    typedef struct packed {
        logic       initiator_mode;
        logic       low_level_mode;
        logic       req_edge;
        logic [2:0] target_phase;
        logic [2:0] expected_phase;
        logic       atn_asserted;
        logic       arb_done;
        logic       arb_sel_done;
        logic       selected_evt;
        logic       reselected_evt;
        logic [2:0] peer_id;
        logic       fifo_underflow;
        logic       fifo_overflow;
        logic       offset_underflow;
        logic       offset_overflow;
        logic       phase_chg_offset;
        logic       residual_fifo;
        logic       disconnect_evt;
        logic       disconnect_expected;
        logic       bus_reset_line;
        logic       scsi_parity_err;
        logic       host_parity_err;
        logic       sel_timeout;
        logic       aux_timer_expired;
        logic       handshake_gap_timeout;
    } sidc_scsi_evt_type;

    typedef struct packed {
        logic       instr_done;
        logic       dma_irq;
        logic [31:0] adder_sum;
    } sidc_engine_type;
endpackage
